/* File: core/ucc_addr_map.sv */
// address decode: cacheability, line index, tag and sram word index
`timescale 1ns/1ps
`include "ucc_defs.svh"
module ucc_addr_map
  import ucc_pkg::*;
(
  input  wire logic [27:0]      addr_in,       // latched cpu address, bits 31:28 gone
  input  wire ucc_pkg::ucc_mode_t mode_in,     // cache size field
  input  wire logic [26:0]      nc_lo_in,      // non-cacheable region low
  input  wire logic [26:0]      nc_hi_in,      // non-cacheable region high
  output logic                  cacheable_out, // access may use the cache
  output logic [6:0]            index_out,     // line index
  output ucc_pkg::ucc_tag_t     tag_out,       // tag bits 26:10
  output ucc_pkg::ucc_widx_t    sram_idx_out,  // array word for sram access
  output logic                  sram_ok_out    // sram offset is backed
);
  // ==========================================================
  // decode
  always_comb begin
    cacheable_out = !((addr_in[26:0] >= nc_lo_in) && (addr_in[26:0] <= nc_hi_in))
                    && (mode_in != `UCC_MODE_0KB);
    if (addr_in[`UCC_NC_BIT]) begin
      cacheable_out = 1'b0;
    end
    tag_out = addr_in[26:10];
    // 2KB cache only uses the lower 64 lines
    if (mode_in == `UCC_MODE_4KB) begin
      index_out = addr_in[10:4];
    end else begin
      index_out = {1'b0, addr_in[9:4]};
    end
    // sram: whole array at 0x000 with no cache, 2KB at 0x800 in 2KB mode, none in 4KB mode
    case (mode_in)
      `UCC_MODE_4KB: begin
        sram_ok_out  = 1'b0;
        sram_idx_out = addr_in[11:2];
      end
      `UCC_MODE_2KB: begin
        sram_ok_out  = addr_in[11];
        sram_idx_out = {addr_in[10], 1'b1, addr_in[9:4], addr_in[3:2]};
      end
      default: begin
        sram_ok_out  = 1'b1;
        sram_idx_out = addr_in[11:2];
      end
    endcase
  end
endmodule

/* File: core/ucc_top.sv */
// unified two-way write-through cache controller with internal sram
// ==========================================================
// Notes on behaviour
// - one 4KB array for code and data
// - two ways per line index
// - evict the least recently used way
// - every cached write also goes to memory
// - read miss fills four consecutive words
// - cache off sends every non-sram access to memory
// - array is 4KB, 2KB+2KB or 4KB sram
// - non-cacheable region bypasses, never allocates
// - 128MB range, low address bits only
// - bit 27 clear: cache if region cacheable
// - bit 27 set: always non-cacheable
// - memory side uses address bits 26:0
// - bits 31:28 and 31:27 are ignored
// - enable bit switches whole cache
// - size field, 4KB after reset
// - spare array as sram at 0x000/0x800
`timescale 1ns/1ps
`include "ucc_defs.svh"
module ucc_top
  import ucc_pkg::*;
(
  input  wire logic        clk_in,         // 250 MHz clock
  input  wire logic        rst_in,         // sync reset, high
  input  wire logic        cfg_wr_in,      // write system config word
  input  wire logic [31:0] cfg_data_in,    // new config word
  input  wire logic [26:0] nc_lo_in,       // non-cacheable low bound
  input  wire logic [26:0] nc_hi_in,       // non-cacheable high bound
  input  wire logic        req_in,         // cpu request
  input  wire logic        we_in,          // cpu write
  input  wire logic        sram_sel_in,    // cpu targets internal sram
  input  wire logic [31:0] addr_in,        // cpu byte address
  input  wire logic [31:0] wdata_in,       // cpu write data
  input  wire logic        mem_ack_in,     // memory done pulse
  input  wire logic [31:0] mem_rdata_in,   // memory read data
  output logic             busy_out,       // request in progress
  output logic             ack_out,        // cpu done pulse
  output logic [31:0]      rdata_out,      // cpu read data
  output logic [31:0]      system_config_word_out, // config readback
  output logic             mem_req_out,    // memory request level
  output logic             mem_we_out,     // memory write
  output logic [26:0]      mem_addr_out,   // memory address
  output logic [31:0]      mem_wdata_out   // memory write data
);
  import ucc_pkg::*;

  // ==========================================================
  // helpers
  // tag compare: 4KB ignores bit 10, which is part of the index
  function automatic logic tag_match(input ucc_tag_t stored, input ucc_tag_t want,
                                     input ucc_mode_t mode);
    if (mode == `UCC_MODE_4KB) begin
      tag_match = (stored[16:1] == want[16:1]);
    end else begin
      tag_match = (stored == want);
    end
  endfunction

  // ==========================================================
  // storage
  logic [31:0]  data_mem [`UCC_WORDS];      // shared 4KB array {way,line,word}
  ucc_tag_t     tag_mem0 [`UCC_LINES];      // way 0 tags
  ucc_tag_t     tag_mem1 [`UCC_LINES];      // way 1 tags
  logic [`UCC_LINES-1:0] valid0;            // way 0 valid
  logic [`UCC_LINES-1:0] valid1;            // way 1 valid
  logic [`UCC_LINES-1:0] lru;               // way to evict next

  // ==========================================================
  // state
  ucc_state_e  state, next_state;           // controller state
  logic [27:0] lat_addr, next_lat_addr;     // latched address
  logic        lat_we, next_lat_we;         // latched write flag
  logic        lat_sram, next_lat_sram;     // latched sram select
  logic [31:0] lat_wdata, next_lat_wdata;   // latched write data
  logic        fill_way, next_fill_way;     // way being filled
  logic [1:0]  fill_cnt, next_fill_cnt;     // word within fill
  logic        ack, next_ack;               // ack flop
  logic [31:0] rdata, next_rdata;           // read data flop
  logic        mem_req, next_mem_req;       // memory request flop
  logic        mem_we, next_mem_we;         // memory write flop
  logic [26:0] mem_addr, next_mem_addr;     // memory address flop
  logic [31:0] mem_wdata, next_mem_wdata;   // memory data flop
  logic [31:0] cfg, next_cfg;               // system config word
  logic        flush;                       // drop all lines

  // array write controls
  logic        dw_en;                       // data word write
  ucc_widx_t   dw_idx;                      // data word index
  logic [31:0] dw_data;                     // data word value
  logic        tag_we;                      // store tag, set valid
  logic        vclr;                        // clear victim valid
  logic        lru_we;                      // update lru
  logic        lru_val;                     // new lru value

  // decode of latched address
  logic        cacheable;                   // region allows caching
  logic [6:0]  idx;                         // line index
  ucc_tag_t    tag;                         // address tag
  ucc_widx_t   sram_idx;                    // sram word
  logic        sram_ok;                     // sram offset backed
  ucc_mode_t   mode;                        // cache size field
  logic        cache_on;                    // cache usable
  logic        use_cache;                   // this access uses cache
  logic        hit0, hit1, hit;             // lookup results
  logic        victim;                      // way to refill

  assign mode = cfg[`UCC_CFG_MODE_HI:`UCC_CFG_MODE_LO];

  ucc_addr_map u_map (
    .addr_in       (lat_addr),
    .mode_in       (mode),
    .nc_lo_in      (nc_lo_in),
    .nc_hi_in      (nc_hi_in),
    .cacheable_out (cacheable),
    .index_out     (idx),
    .tag_out       (tag),
    .sram_idx_out  (sram_idx),
    .sram_ok_out   (sram_ok)
  );

  // ==========================================================
  // lookup
  always_comb begin
    cache_on  = cfg[`UCC_CFG_CE_BIT] && ((mode == `UCC_MODE_4KB) || (mode == `UCC_MODE_2KB));
    use_cache = cache_on && cacheable && !lat_sram;
    hit0      = valid0[idx] && tag_match(tag_mem0[idx], tag, mode);
    hit1      = valid1[idx] && tag_match(tag_mem1[idx], tag, mode);
    hit       = use_cache && (hit0 || hit1);
    victim    = !valid0[idx] ? 1'b0 : (!valid1[idx] ? 1'b1 : lru[idx]);
    flush     = cfg_wr_in && (cfg_data_in[`UCC_CFG_MODE_HI:`UCC_CFG_MODE_LO] != mode);
  end

  // ==========================================================
  // controller next values
  always_comb begin
    next_state     = state;
    next_lat_addr  = lat_addr;
    next_lat_we    = lat_we;
    next_lat_sram  = lat_sram;
    next_lat_wdata = lat_wdata;
    next_fill_way  = fill_way;
    next_fill_cnt  = fill_cnt;
    next_ack       = 1'b0;
    next_rdata     = rdata;
    next_mem_req   = mem_req;
    next_mem_we    = mem_we;
    next_mem_addr  = mem_addr;
    next_mem_wdata = mem_wdata;
    next_cfg       = cfg_wr_in ? cfg_data_in : cfg;
    dw_en   = 1'b0;
    dw_idx  = {hit1, idx, lat_addr[3:2]};
    dw_data = lat_wdata;
    tag_we  = 1'b0;
    vclr    = 1'b0;
    lru_we  = 1'b0;
    lru_val = 1'b0;
    case (state)
      S_IDLE: begin
        if (req_in) begin
          next_lat_addr  = addr_in[27:0];
          next_lat_we    = we_in;
          next_lat_sram  = sram_sel_in;
          next_lat_wdata = wdata_in;
          next_state     = S_LOOK;
        end
      end
      S_LOOK: begin
        if (lat_sram) begin
          // sram access, unbacked offsets read zero
          dw_idx     = sram_idx;
          dw_en      = lat_we && sram_ok;
          next_rdata = sram_ok ? data_mem[sram_idx] : 32'h00000000;
          next_ack   = 1'b1;
          next_state = S_IDLE;
        end else if (hit) begin
          lru_we  = 1'b1;
          lru_val = !hit1;
          if (lat_we) begin
            dw_en          = 1'b1;
            next_mem_req   = 1'b1;
            next_mem_we    = 1'b1;
            next_mem_addr  = lat_addr[26:0];
            next_mem_wdata = lat_wdata;
            next_state     = S_MEM;
          end else begin
            next_rdata = data_mem[{hit1, idx, lat_addr[3:2]}];
            next_ack   = 1'b1;
            next_state = S_IDLE;
          end
        end else if (use_cache && !lat_we) begin
          // start four word fill into victim
          vclr          = 1'b1;
          next_fill_way = victim;
          next_fill_cnt = 2'h0;
          next_mem_req  = 1'b1;
          next_mem_we   = 1'b0;
          next_mem_addr = {lat_addr[26:4], 4'h0};
          next_state    = S_FILL;
        end else begin
          next_mem_req   = 1'b1;
          next_mem_we    = lat_we;
          next_mem_addr  = lat_addr[26:0];
          next_mem_wdata = lat_wdata;
          next_state     = S_MEM;
        end
      end
      S_FILL: begin
        if (mem_ack_in) begin
          dw_en   = 1'b1;
          dw_idx  = {fill_way, idx, fill_cnt};
          dw_data = mem_rdata_in;
          if (fill_cnt == lat_addr[3:2]) begin
            next_rdata = mem_rdata_in;
          end
          if (fill_cnt == `UCC_LAST_WORD) begin
            tag_we       = 1'b1;
            lru_we       = 1'b1;
            lru_val      = !fill_way;
            next_mem_req = 1'b0;
            next_ack     = 1'b1;
            next_state   = S_IDLE;
          end else begin
            next_fill_cnt = fill_cnt + 2'h1;
            next_mem_addr = {lat_addr[26:4], fill_cnt + 2'h1, 2'h0};
          end
        end
      end
      S_MEM: begin
        if (mem_ack_in) begin
          next_mem_req = 1'b0;
          if (!lat_we) begin
            next_rdata = mem_rdata_in;
          end
          next_ack   = 1'b1;
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // ==========================================================
  // controller registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state     <= S_IDLE;
      lat_addr  <= 28'h0000000;
      lat_we    <= 1'b0;
      lat_sram  <= 1'b0;
      lat_wdata <= 32'h00000000;
      fill_way  <= 1'b0;
      fill_cnt  <= 2'h0;
      ack       <= 1'b0;
      rdata     <= 32'h00000000;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= 27'h0000000;
      mem_wdata <= 32'h00000000;
      cfg       <= `UCC_CFG_RESET;
    end else begin
      state     <= next_state;
      lat_addr  <= next_lat_addr;
      lat_we    <= next_lat_we;
      lat_sram  <= next_lat_sram;
      lat_wdata <= next_lat_wdata;
      fill_way  <= next_fill_way;
      fill_cnt  <= next_fill_cnt;
      ack       <= next_ack;
      rdata     <= next_rdata;
      mem_req   <= next_mem_req;
      mem_we    <= next_mem_we;
      mem_addr  <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      cfg       <= next_cfg;
    end
  end

  // ==========================================================
  // array registers
  always_ff @(posedge clk_in) begin
    if (dw_en) begin
      data_mem[dw_idx] <= dw_data;
    end
    if (tag_we && !fill_way) begin
      tag_mem0[idx] <= tag;
    end
    if (tag_we && fill_way) begin
      tag_mem1[idx] <= tag;
    end
  end

  // valid and lru; a size change drops every line
  always_ff @(posedge clk_in) begin
    if (rst_in || flush) begin
      valid0 <= '0;
      valid1 <= '0;
      lru    <= '0;
    end else begin
      if (vclr && !next_fill_way) valid0[idx] <= 1'b0;
      if (vclr && next_fill_way)  valid1[idx] <= 1'b0;
      if (tag_we && !fill_way)    valid0[idx] <= 1'b1;
      if (tag_we && fill_way)     valid1[idx] <= 1'b1;
      if (lru_we)                 lru[idx]    <= lru_val;
    end
  end

  assign busy_out               = (state != S_IDLE);
  assign ack_out                = ack;
  assign rdata_out              = rdata;
  assign system_config_word_out = cfg;
  assign mem_req_out            = mem_req;
  assign mem_we_out             = mem_we;
  assign mem_addr_out           = mem_addr;
  assign mem_wdata_out          = mem_wdata;

  // ==========================================================
  // checks
  wt_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state == S_LOOK && hit && lat_we) |=> (mem_req_out && mem_we_out && state == S_MEM))
    else $error("write hit not written through");
  fill_done_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state == S_FILL && mem_ack_in && fill_cnt == 2'h3) |=> (ack_out && state == S_IDLE))
    else $error("fill did not end after fourth word");
  fill_addr_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state == S_FILL) |-> (mem_addr_out[3:2] == fill_cnt && !mem_we_out))
    else $error("fill address not consecutive");
  off_bypass_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state == S_LOOK && !lat_sram && !cfg[`UCC_CFG_CE_BIT]) |=> (state == S_MEM))
    else $error("cache off access not sent to memory");
  nc_noalloc_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state == S_LOOK && !cacheable) |=> (state != S_FILL))
    else $error("non-cacheable access allocated");
  bit27_nc_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state == S_LOOK && !lat_sram && lat_addr[27]) |=> (state == S_MEM && mem_req_out))
    else $error("bit 27 access was cached");
  mem_addr_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state == S_MEM) |-> (mem_addr_out == lat_addr[26:0]))
    else $error("memory address not bits 26:0");
  wmiss_noalloc_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state == S_LOOK && lat_we && !hit) |=> (state != S_FILL))
    else $error("write miss allocated");
  lru_victim_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state == S_LOOK && next_state == S_FILL && valid0[idx] && valid1[idx])
      |=> (fill_way == $past(lru[idx])))
    else $error("victim not least recently used");
  reset_size_a: assert property (@(posedge clk_in)
    $past(rst_in) |-> (mode == `UCC_MODE_4KB))
    else $error("size not 4KB after reset");
  sram_keep_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state == S_FILL && mode == `UCC_MODE_2KB) |-> (idx[6] == 1'b0))
    else $error("fill touched sram lines");

  fill_c: cover property (@(posedge clk_in) disable iff (rst_in)
    state == S_FILL && mem_ack_in && fill_cnt == 2'h3);
  hit_c: cover property (@(posedge clk_in) disable iff (rst_in)
    state == S_LOOK && hit && !lat_we);
  evict_c: cover property (@(posedge clk_in) disable iff (rst_in)
    state == S_LOOK && next_state == S_FILL && valid0[idx] && valid1[idx]);
  sram_c: cover property (@(posedge clk_in) disable iff (rst_in)
    state == S_LOOK && lat_sram && sram_ok && lat_we);
endmodule

/* File: inc/ucc_defs.svh */
// constants of the unified cache controller
`ifndef UCC_DEFS_SVH
`define UCC_DEFS_SVH
`define UCC_WORDS        1024
`define UCC_LINES        128
`define UCC_LINE_WORDS   4
`define UCC_CFG_CE_BIT   1
`define UCC_CFG_MODE_HI  16
`define UCC_CFG_MODE_LO  15
`define UCC_MODE_0KB     2'h0
`define UCC_MODE_2KB     2'h1
`define UCC_MODE_4KB     2'h2
`define UCC_CFG_RESET    32'h00010000
`define UCC_NC_BIT       27
`define UCC_LAST_WORD    2'h3
`endif

/* File: inc/ucc_pkg.sv */
// types of the unified cache controller
package ucc_pkg;
  typedef enum logic [1:0] {S_IDLE, S_LOOK, S_FILL, S_MEM} ucc_state_e;
  typedef logic [1:0]  ucc_mode_t;
  typedef logic [9:0]  ucc_widx_t;
  typedef logic [16:0] ucc_tag_t;
endpackage

/* File: verification/ucc_mem_model.sv */
// memory-controller model that answers the cache controller word by word
`timescale 1ns/1ps
module ucc_mem_model (
  input  wire logic        clk_in,        // system clock
  input  wire logic        rst_in,        // sync reset, high
  input  wire logic        slow_in,       // insert wait cycles
  input  wire logic        mem_req_in,    // request level
  input  wire logic        mem_we_in,     // write request
  input  wire logic [26:0] mem_addr_in,   // byte address
  input  wire logic [31:0] mem_wdata_in,  // write data
  output logic             mem_ack_out,   // one-cycle done pulse
  output logic [31:0]      mem_rdata_out  // read data
);
  logic [31:0] mem [0:4095];  // backing words, address bits 13:2
  int          rd_cnt;        // reads served
  int          wr_cnt;        // writes served
  int          wait_cnt;      // cycles left before answering
  logic [26:0] last_addr;     // address of last served word
  // ==========================================================
  // preload
  initial begin
    mem_ack_out   = 1'b0;
    mem_rdata_out = 32'h0;
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 32'hC3000000 | i;
    end
  end
  // ==========================================================
  // one word per request; data lines scramble outside the answer cycle
  always @(posedge clk_in) begin
    mem_ack_out   <= 1'b0;
    mem_rdata_out <= ~mem_rdata_out;
    if (rst_in) begin
      rd_cnt   <= 0;
      wr_cnt   <= 0;
      wait_cnt <= 0;
    end else if (mem_ack_out) begin
      // gap after a word: the controller moves its request first
      wait_cnt <= slow_in ? 3 : 0;
    end else if (mem_req_in && wait_cnt != 0) begin
      wait_cnt <= wait_cnt - 1;
    end else if (mem_req_in) begin
      mem_ack_out <= 1'b1;
      last_addr   <= mem_addr_in;
      if (mem_we_in) begin
        mem[mem_addr_in[13:2]] <= mem_wdata_in;
        wr_cnt                 <= wr_cnt + 1;
      end else begin
        mem_rdata_out <= mem[mem_addr_in[13:2]];
        rd_cnt        <= rd_cnt + 1;
      end
    end
  end
endmodule

/* File: verification/unified_cache_controller_tb_top.sv */
// self-checking bench of the unified cache controller
`timescale 1ns/1ps
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp); end end
module unified_cache_controller_tb_top;
  logic        clk_in, rst_in, cfg_wr_in, req_in, we_in, sram_sel_in, slow;
  logic [31:0] cfg_data_in, addr_in, wdata_in, mem_rdata_in, rdata_out;
  logic [31:0] system_config_word_out, mem_wdata_out, e_v, d;
  logic [26:0] nc_lo_in, nc_hi_in, mem_addr_out;
  logic        mem_ack_in, busy_out, ack_out, mem_req_out, mem_we_out, c_v;
  logic [31:0] sh [0:4095];  // expected memory contents
  logic [31:0] sd [0:3];     // expected sram words
  logic [31:0] exp_q [$];    // expected read data per answer
  logic        chk_q [$];    // answer carries read data
  int          error_cnt, check_count, cyc;
  ucc_top uut (.clk_in(clk_in), .rst_in(rst_in), .cfg_wr_in(cfg_wr_in),
    .cfg_data_in(cfg_data_in), .nc_lo_in(nc_lo_in), .nc_hi_in(nc_hi_in), .req_in(req_in),
    .we_in(we_in), .sram_sel_in(sram_sel_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in), .busy_out(busy_out),
    .ack_out(ack_out), .rdata_out(rdata_out), .system_config_word_out(system_config_word_out),
    .mem_req_out(mem_req_out), .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out));
  ucc_mem_model mem_m (.clk_in(clk_in), .rst_in(rst_in), .slow_in(slow),
    .mem_req_in(mem_req_out), .mem_we_in(mem_we_out), .mem_addr_in(mem_addr_out),
    .mem_wdata_in(mem_wdata_out), .mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in));
  // ==========================================================
  // clock, 4 ns period
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // ==========================================================
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc >= 6000) begin
      error_cnt++;
      complete_run();
    end
  end
  // ==========================================================
  // config word write and readback
  task automatic cfg(input logic [31:0] w);
    @(negedge clk_in);
    cfg_wr_in   = 1'b1;
    cfg_data_in = w;
    @(negedge clk_in);
    cfg_wr_in = 1'b0;
    `CHK(system_config_word_out, w)
  endtask
  // one cpu access with expected memory traffic
  task automatic op(input logic we, input logic sel, input logic [31:0] a,
                    input logic [31:0] wd, input int nrd, input int nwr,
                    input logic [31:0] ex);
    int rd0, wr0, n;
    rd0 = mem_m.rd_cnt;
    wr0 = mem_m.wr_cnt;
    n   = 0;
    exp_q.push_back(ex);
    chk_q.push_back(!we);
    if (we && !sel) begin
      sh[a[13:2]] = wd;
    end
    @(negedge clk_in);
    req_in      = 1'b1;
    we_in       = we;
    sram_sel_in = sel;
    addr_in     = a;
    wdata_in    = wd;
    @(negedge clk_in);
    req_in = 1'b0;
    while (ack_out !== 1'b1 && n < 200) begin
      @(negedge clk_in);
      n++;
    end
    `CHK(ack_out, 1'b1)
    `CHK(busy_out, 1'b0)
    `CHK(32'(mem_m.rd_cnt - rd0), 32'(nrd))
    `CHK(32'(mem_m.wr_cnt - wr0), 32'(nwr))
    if (nrd == 0 && nwr == 0) `CHK(32'(n), 32'h1)
    if (nrd == 4) `CHK(mem_m.last_addr, {a[26:4], 4'hC})
    if (nrd + nwr == 1) `CHK(mem_m.last_addr, a[26:0])
  endtask
  task automatic rd(input logic [31:0] a, input int n);
    op(1'b0, 1'b0, a, 32'h0, n, 0, sh[a[13:2]]);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    op(1'b1, 1'b0, a, v, 0, 1, 32'h0);
  endtask
  // ==========================================================
  // answer watcher: oldest note against each answer
  always @(negedge clk_in) begin
    if (ack_out === 1'b1 && exp_q.size() > 0) begin
      e_v = exp_q.pop_front();
      c_v = chk_q.pop_front();
      if (c_v) `CHK(rdata_out, e_v)
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    rst_in = 1'b1;
    {cfg_wr_in, req_in, we_in, sram_sel_in, slow} = 5'h00;
    {cfg_data_in, addr_in, wdata_in} = 96'h0;
    nc_lo_in = 27'h2000;
    nc_hi_in = 27'h2FFF;
    {error_cnt, check_count, cyc} = 0;
    for (int i = 0; i < 4096; i++) begin
      sh[i] = 32'hC3000000 | i;
    end
    void'($urandom(32));
    repeat (10) @(negedge clk_in);
    rst_in = 1'b0;
    `CHK(system_config_word_out, 32'h00010000)
    // cache off: each read goes out
    rd(32'hF0000040, 1);
    rd(32'hF0000040, 1);
    cfg(32'h00010002);
    // three tags on one index
    rd(32'h00000040, 4);
    rd(32'h00000044, 0);
    rd(32'h10000840, 4);
    rd(32'h00000048, 0);
    rd(32'h0000084C, 0);
    rd(32'h00000040, 0);
    rd(32'h00001040, 4);
    rd(32'h00000040, 0);
    rd(32'h00000840, 4);
    slow = 1'b1;
    d = $urandom();
    wr(32'h00000040, d);
    rd(32'h00000040, 0);
    wr(32'h00001844, $urandom());
    rd(32'h00001844, 4);
    // region and bit 27 bypass
    rd(32'h00002100, 1);
    rd(32'h00002100, 1);
    rd(32'h00002FFC, 1);
    rd(32'h00003000, 4);
    rd(32'h00003004, 0);
    rd(32'h08000040, 1);
    rd(32'hF8003000, 1);
    nc_lo_in = 27'h3000;
    nc_hi_in = 27'h30FF;
    rd(32'h00003008, 1);
    slow = 1'b0;
    // whole array as sram
    cfg(32'h00000002);
    for (int k = 0; k < 4; k++) begin
      sd[k] = $urandom();
      op(1'b1, 1'b1, 32'(k * 32'h3FC + 32'h4), sd[k], 0, 0, 32'h0);
    end
    for (int k = 0; k < 4; k++) begin
      op(1'b0, 1'b1, 32'(k * 32'h3FC + 32'h4), 32'h0, 0, 0, sd[k]);
    end
    rd(32'h00000040, 1);
    // half cache, half sram
    cfg(32'h00008002);
    d = $urandom();
    op(1'b1, 1'b1, 32'h00000800, d, 0, 0, 32'h0);
    op(1'b1, 1'b1, 32'h00000004, $urandom(), 0, 0, 32'h0);
    op(1'b0, 1'b1, 32'h00000004, 32'h0, 0, 0, 32'h0);
    rd(32'h00000040, 4);
    rd(32'h00000040, 0);
    rd(32'h000003F0, 4);
    rd(32'h00000BF4, 4);
    rd(32'h000003F4, 0);
    op(1'b0, 1'b1, 32'h00000800, 32'h0, 0, 0, d);
    complete_run();
  end
endmodule
